// ---- verilog/tcd_top.sv ----
// Time counter, time-code receive check and transmit insertion
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
module tcd_top (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_axi_awvalid,
    output logic o_axi_awready,
    input wire logic [4:0] i_axi_awaddr,
    input wire logic i_axi_wvalid,
    output logic o_axi_wready,
    input wire logic [31:0] i_axi_wdata,
    input wire logic [3:0] i_axi_wstrb,
    output logic o_axi_bvalid,
    input wire logic i_axi_bready,
    output logic [1:0] o_axi_bresp,
    input wire logic i_axi_arvalid,
    output logic o_axi_arready,
    input wire logic [4:0] i_axi_araddr,
    output logic o_axi_rvalid,
    input wire logic i_axi_rready,
    output logic [31:0] o_axi_rdata,
    output logic [1:0] o_axi_rresp,
    input wire logic i_tick_in,
    input wire logic i_link_run,
    input wire logic i_link_err_reset,
    input wire logic i_link_clk,
    input wire logic i_rx_tc_stb,
    input wire logic [7:0] i_rx_tc_code,
    input wire logic i_tx_busy,
    input wire logic i_tx_char_end,
    output logic o_tx_tc_valid,
    output logic [7:0] o_tx_tc_code,
    output logic o_tick_out,
    output logic [5:0] o_time,
    output logic [1:0] o_ctrl_flags,
    output logic o_irq
);
    typedef struct packed {
        logic [5:0] cnt;
        logic [1:0] flags;
        tcd_pkg::tcd_tx_state_type tx;
        logic [7:0] tx_code;
        logic tx_valid;
        logic tick_out;
        logic [7:0] ctrl;
        logic [4:0] irq_stat;
        logic [4:0] irq_mask;
        logic irq;
        logic [7:0] last_rx;
        logic [7:0] last_tx;
        logic [7:0] n_valid;
        logic [7:0] n_invalid;
        logic [7:0] n_ignored;
    } tcd_core_state_type;

    tcd_reg_if regs ();
    tcd_rx_if rx ();

    tcd_core_state_type st_ff;
    tcd_core_state_type nxt_st;

    tcd_axil u_axil (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_awvalid(i_axi_awvalid),
        .o_awready(o_axi_awready),
        .i_awaddr(i_axi_awaddr),
        .i_wvalid(i_axi_wvalid),
        .o_wready(o_axi_wready),
        .i_wdata(i_axi_wdata),
        .i_wstrb(i_axi_wstrb),
        .o_bvalid(o_axi_bvalid),
        .i_bready(i_axi_bready),
        .o_bresp(o_axi_bresp),
        .i_arvalid(i_axi_arvalid),
        .o_arready(o_axi_arready),
        .i_araddr(i_axi_araddr),
        .o_rvalid(o_axi_rvalid),
        .i_rready(i_axi_rready),
        .o_rdata(o_axi_rdata),
        .o_rresp(o_axi_rresp),
        .regs(regs)
    );

    tcd_rx_sync u_rx_sync (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_link_clk(i_link_clk),
        .i_rx_stb(i_rx_tc_stb),
        .i_rx_code(i_rx_tc_code),
        .rx(rx)
    );

    logic [5:0] time_inc;
    logic [5:0] rx_time;
    logic [1:0] rx_flags;
    logic [1:0] own_flags;
    logic master;
    logic sw_tick;
    logic queue;
    logic [7:0] queue_code;
    logic [4:0] ev;
    logic stat_clr;

    always_comb begin
        nxt_st = st_ff;
        ev = '0;
        queue = 1'b0;
        queue_code = st_ff.tx_code;
        nxt_st.tick_out = 1'b0;
        nxt_st.tx_valid = 1'b0;
        master = st_ff.ctrl[tcd_pkg::TCD_CTRL_MASTER];
        own_flags = st_ff.ctrl[tcd_pkg::TCD_CTRL_FLAG_LSB +: 2];
        time_inc = st_ff.cnt + tcd_pkg::TCD_TIME_ONE;
        rx_time = rx.code[tcd_pkg::TCD_CODE_TIME_LSB +: 6];
        rx_flags = rx.code[tcd_pkg::TCD_CODE_FLAG_LSB +: 2];

        // Register writes
        regs.wr_err = !(regs.wr_addr == tcd_pkg::TCD_OFF_CTRL ||
            regs.wr_addr == tcd_pkg::TCD_OFF_STATUS ||
            regs.wr_addr == tcd_pkg::TCD_OFF_IRQ_STAT ||
            regs.wr_addr == tcd_pkg::TCD_OFF_IRQ_MASK ||
            regs.wr_addr == tcd_pkg::TCD_OFF_LAST ||
            regs.wr_addr == tcd_pkg::TCD_OFF_COUNTS ||
            regs.wr_addr == tcd_pkg::TCD_OFF_SWTICK);
        // Decoded only after the error flag is settled
        sw_tick = regs.wr_stb && !regs.wr_err && regs.wstrb[0] &&
            regs.wr_addr == tcd_pkg::TCD_OFF_SWTICK && regs.wdata[0];
        if (regs.wr_stb && regs.wstrb[0]) begin
            if (regs.wr_addr == tcd_pkg::TCD_OFF_CTRL) begin
                nxt_st.ctrl = regs.wdata[7:0];
            end
            if (regs.wr_addr == tcd_pkg::TCD_OFF_IRQ_MASK) begin
                nxt_st.irq_mask = regs.wdata[4:0];
            end
            if (regs.wr_addr == tcd_pkg::TCD_OFF_COUNTS) begin
                nxt_st.n_valid = '0;
                nxt_st.n_invalid = '0;
                nxt_st.n_ignored = '0;
            end
        end

        // Register reads
        regs.rd_err = 1'b0;
        regs.rdata = '0;
        case (regs.rd_addr)
            tcd_pkg::TCD_OFF_CTRL: begin
                regs.rdata[7:0] = st_ff.ctrl;
            end
            tcd_pkg::TCD_OFF_STATUS: begin
                regs.rdata[5:0] = st_ff.cnt;
                regs.rdata[tcd_pkg::TCD_STAT_FLAG_LSB +: 2] = st_ff.flags;
                regs.rdata[tcd_pkg::TCD_STAT_PEND] =
                    st_ff.tx != tcd_pkg::TCD_TX_IDLE;
                regs.rdata[tcd_pkg::TCD_STAT_RUN] = i_link_run;
            end
            tcd_pkg::TCD_OFF_IRQ_STAT: begin
                regs.rdata[4:0] = st_ff.irq_stat;
            end
            tcd_pkg::TCD_OFF_IRQ_MASK: begin
                regs.rdata[4:0] = st_ff.irq_mask;
            end
            tcd_pkg::TCD_OFF_LAST: begin
                regs.rdata[7:0] = st_ff.last_rx;
                regs.rdata[tcd_pkg::TCD_LAST_TX_LSB +: 8] = st_ff.last_tx;
            end
            tcd_pkg::TCD_OFF_COUNTS: begin
                regs.rdata[7:0] = st_ff.n_valid;
                regs.rdata[tcd_pkg::TCD_CNT_INV_LSB +: 8] = st_ff.n_invalid;
                regs.rdata[tcd_pkg::TCD_CNT_IGN_LSB +: 8] = st_ff.n_ignored;
            end
            tcd_pkg::TCD_OFF_SWTICK: begin
                regs.rdata = '0;
            end
            default: begin
                regs.rd_err = 1'b1;
            end
        endcase
        stat_clr = regs.rd_stb && regs.rd_addr == tcd_pkg::TCD_OFF_IRQ_STAT;

        // Master tick wins over a code arriving in the same cycle
        if (master && (i_tick_in || sw_tick)) begin
            nxt_st.cnt = time_inc;
            queue = 1'b1;
            queue_code = {own_flags, time_inc};
            ev[tcd_pkg::TCD_EV_MASTER] = 1'b1;
        end else if (rx.valid) begin
            nxt_st.last_rx = rx.code;
            if (rx_time == st_ff.cnt) begin
                // Stops time running round a loop of links
                ev[tcd_pkg::TCD_EV_IGNORED] = 1'b1;
                nxt_st.n_ignored = st_ff.n_ignored + tcd_pkg::TCD_CNT_ONE;
            end else if (rx_time == time_inc) begin
                nxt_st.cnt = time_inc;
                nxt_st.tick_out = 1'b1;
                nxt_st.flags = rx_flags;
                ev[tcd_pkg::TCD_EV_TICK] = 1'b1;
                nxt_st.n_valid = st_ff.n_valid + tcd_pkg::TCD_CNT_ONE;
                queue = st_ff.ctrl[tcd_pkg::TCD_CTRL_FWD];
                queue_code = {rx_flags, time_inc};
            end else begin
                nxt_st.cnt = rx_time;
                ev[tcd_pkg::TCD_EV_INVALID] = 1'b1;
                nxt_st.n_invalid = st_ff.n_invalid + tcd_pkg::TCD_CNT_ONE;
            end
        end

        // Transmit insertion; a newer code replaces an unsent one
        case (st_ff.tx)
            tcd_pkg::TCD_TX_IDLE: begin
                if (queue) begin
                    nxt_st.tx = tcd_pkg::TCD_TX_HOLD;
                    nxt_st.tx_code = queue_code;
                end
            end
            tcd_pkg::TCD_TX_HOLD: begin
                if (queue) begin
                    nxt_st.tx_code = queue_code;
                end
                if (i_link_run &&
                    (!i_tx_busy || i_tx_char_end)) begin
                    nxt_st.tx = tcd_pkg::TCD_TX_SEND;
                    nxt_st.tx_valid = 1'b1;
                end
            end
            tcd_pkg::TCD_TX_SEND: begin
                ev[tcd_pkg::TCD_EV_SENT] = 1'b1;
                nxt_st.last_tx = st_ff.tx_code;
                if (queue) begin
                    nxt_st.tx = tcd_pkg::TCD_TX_HOLD;
                    nxt_st.tx_code = queue_code;
                end else begin
                    nxt_st.tx = tcd_pkg::TCD_TX_IDLE;
                end
            end
            default: begin
                nxt_st.tx = tcd_pkg::TCD_TX_IDLE;
            end
        endcase

        // A stale code must not leak out after the link restarts
        if (i_link_err_reset) begin
            nxt_st.cnt = tcd_pkg::TCD_TIME_RST;
            nxt_st.flags = tcd_pkg::TCD_FLAG_RST;
            nxt_st.tick_out = 1'b0;
            nxt_st.tx_valid = 1'b0;
            nxt_st.tx = tcd_pkg::TCD_TX_IDLE;
        end

        // Read clears, but an event in the same cycle survives
        nxt_st.irq_stat = (stat_clr ? '0 : st_ff.irq_stat) | ev;
        nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);

        if (!i_rst_b) begin
            nxt_st = '0;
            nxt_st.cnt = tcd_pkg::TCD_TIME_RST;
            nxt_st.flags = tcd_pkg::TCD_FLAG_RST;
            nxt_st.ctrl = tcd_pkg::TCD_CTRL_RST;
            nxt_st.irq_mask = tcd_pkg::TCD_MASK_RST;
            nxt_st.tx = tcd_pkg::TCD_TX_IDLE;
        end
    end

    always_ff @(posedge i_clk) begin
        st_ff <= nxt_st;
    end

    assign o_tx_tc_valid = st_ff.tx_valid;
    assign o_tx_tc_code = st_ff.tx_code;
    assign o_tick_out = st_ff.tick_out;
    assign o_time = st_ff.cnt;
    assign o_ctrl_flags = st_ff.flags;
    assign o_irq = st_ff.irq;
endmodule

// ---- verilog/tcd_pkg.sv ----
// Constants and types shared by the time-code distribution block
package tcd_pkg;
    localparam int unsigned TCD_ADDR_W = 5;
    localparam int unsigned TCD_DATA_W = 32;
    localparam int unsigned TCD_TIME_W = 6;
    localparam int unsigned TCD_FLAG_W = 2;
    localparam int unsigned TCD_CODE_W = 8;
    localparam int unsigned TCD_EV_W = 5;
    localparam int unsigned TCD_CNT_W = 8;
    // Register byte offsets
    localparam logic [4:0] TCD_OFF_CTRL = 5'h00;
    localparam logic [4:0] TCD_OFF_STATUS = 5'h04;
    localparam logic [4:0] TCD_OFF_IRQ_STAT = 5'h08;
    localparam logic [4:0] TCD_OFF_IRQ_MASK = 5'h0C;
    localparam logic [4:0] TCD_OFF_LAST = 5'h10;
    localparam logic [4:0] TCD_OFF_COUNTS = 5'h14;
    localparam logic [4:0] TCD_OFF_SWTICK = 5'h18;
    // Field positions
    localparam int unsigned TCD_CTRL_MASTER = 0;
    localparam int unsigned TCD_CTRL_FWD = 1;
    localparam int unsigned TCD_CTRL_FLAG_LSB = 6;
    localparam int unsigned TCD_CODE_TIME_LSB = 0;
    localparam int unsigned TCD_CODE_FLAG_LSB = 6;
    localparam int unsigned TCD_STAT_FLAG_LSB = 6;
    localparam int unsigned TCD_STAT_PEND = 8;
    localparam int unsigned TCD_STAT_RUN = 9;
    localparam int unsigned TCD_LAST_TX_LSB = 8;
    localparam int unsigned TCD_CNT_INV_LSB = 8;
    localparam int unsigned TCD_CNT_IGN_LSB = 16;
    localparam int unsigned TCD_EV_TICK = 0;
    localparam int unsigned TCD_EV_INVALID = 1;
    localparam int unsigned TCD_EV_IGNORED = 2;
    localparam int unsigned TCD_EV_SENT = 3;
    localparam int unsigned TCD_EV_MASTER = 4;
    // Reset values, step sizes and response codes
    localparam logic [7:0] TCD_CTRL_RST = 8'h00;
    localparam logic [4:0] TCD_MASK_RST = 5'h00;
    localparam logic [5:0] TCD_TIME_RST = 6'h00;
    localparam logic [1:0] TCD_FLAG_RST = 2'h0;
    localparam logic [5:0] TCD_TIME_ONE = 6'h01;
    localparam logic [7:0] TCD_CNT_ONE = 8'h01;
    localparam logic [1:0] TCD_RESP_OKAY = 2'h0;
    localparam logic [1:0] TCD_RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        TCD_TX_IDLE = 3'h1,
        TCD_TX_HOLD = 3'h2,
        TCD_TX_SEND = 3'h4
    } tcd_tx_state_type;
endpackage

// ---- verilog/tcd_if.sv ----
// Internal carriers: register access and received time codes
interface tcd_reg_if;
    logic wr_stb;
    logic [4:0] wr_addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wr_err;
    logic rd_stb;
    logic [4:0] rd_addr;
    logic [31:0] rdata;
    logic rd_err;
    modport slv (output wr_stb, wr_addr, wdata, wstrb, rd_stb, rd_addr,
                 input wr_err, rdata, rd_err);
    modport regs (input wr_stb, wr_addr, wdata, wstrb, rd_stb, rd_addr,
                  output wr_err, rdata, rd_err);
endinterface

interface tcd_rx_if;
    logic valid;
    logic [7:0] code;
    modport src (output valid, code);
    modport dst (input valid, code);
endinterface

// ---- verilog/tcd_axil.sv ----
// AXI4-Lite slave front end for the time-code registers
module tcd_axil (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [4:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [4:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    tcd_reg_if.slv regs
);
    typedef struct packed {
        logic aw_ok;
        logic w_ok;
        logic [4:0] addr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tcd_axil_state_type;

    tcd_axil_state_type st_ff;
    tcd_axil_state_type nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (i_awvalid && st_ff.awready) begin
            nxt_st.aw_ok = 1'b1;
            nxt_st.addr = i_awaddr;
        end
        if (i_wvalid && st_ff.wready) begin
            nxt_st.w_ok = 1'b1;
            nxt_st.wdata = i_wdata;
            nxt_st.wstrb = i_wstrb;
        end
        // Write acts only once both halves are held
        regs.wr_stb = st_ff.aw_ok && st_ff.w_ok && !st_ff.bvalid;
        regs.wr_addr = st_ff.addr;
        regs.wdata = st_ff.wdata;
        regs.wstrb = st_ff.wstrb;
        if (regs.wr_stb) begin
            nxt_st.aw_ok = 1'b0;
            nxt_st.w_ok = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = regs.wr_err ? tcd_pkg::TCD_RESP_SLVERR :
                tcd_pkg::TCD_RESP_OKAY;
        end else if (st_ff.bvalid && i_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        regs.rd_stb = i_arvalid && st_ff.arready;
        regs.rd_addr = i_araddr;
        if (regs.rd_stb) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata = regs.rdata;
            nxt_st.rresp = regs.rd_err ? tcd_pkg::TCD_RESP_SLVERR :
                tcd_pkg::TCD_RESP_OKAY;
        end else if (st_ff.rvalid && i_rready) begin
            nxt_st.rvalid = 1'b0;
        end
        // One write and one read at a time
        nxt_st.awready = !nxt_st.aw_ok && !nxt_st.bvalid;
        nxt_st.wready = !nxt_st.w_ok && !nxt_st.bvalid;
        nxt_st.arready = !nxt_st.rvalid;
        if (!i_rst_b) begin
            nxt_st = '0;
        end
    end

    always_ff @(posedge i_clk) begin
        st_ff <= nxt_st;
    end

    assign o_awready = st_ff.awready;
    assign o_wready = st_ff.wready;
    assign o_bvalid = st_ff.bvalid;
    assign o_bresp = st_ff.bresp;
    assign o_arready = st_ff.arready;
    assign o_rvalid = st_ff.rvalid;
    assign o_rdata = st_ff.rdata;
    assign o_rresp = st_ff.rresp;
endmodule

// ---- verilog/tcd_rx_sync.sv ----
// Samples received time codes from the link clock domain
module tcd_rx_sync (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_link_clk,
    input wire logic i_rx_stb,
    input wire logic [7:0] i_rx_code,
    tcd_rx_if.src rx
);
    typedef struct packed {
        logic clk_s1;
        logic clk_s2;
        logic clk_d;
        logic stb_s1;
        logic stb_s2;
        logic [7:0] code_s1;
        logic [7:0] code_s2;
        logic valid;
        logic [7:0] code;
    } tcd_rx_state_type;

    tcd_rx_state_type st_ff;
    tcd_rx_state_type nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.clk_s1 = i_link_clk;
        nxt_st.clk_s2 = st_ff.clk_s1;
        nxt_st.clk_d = st_ff.clk_s2;
        nxt_st.stb_s1 = i_rx_stb;
        nxt_st.stb_s2 = st_ff.stb_s1;
        nxt_st.code_s1 = i_rx_code;
        nxt_st.code_s2 = st_ff.code_s1;
        // Strobe and code share the clock's latency, so they line up
        nxt_st.valid = st_ff.clk_s2 && !st_ff.clk_d && st_ff.stb_s2;
        if (nxt_st.valid) begin
            nxt_st.code = st_ff.code_s2;
        end
        if (!i_rst_b) begin
            nxt_st = '0;
        end
    end

    always_ff @(posedge i_clk) begin
        st_ff <= nxt_st;
    end

    assign rx.valid = st_ff.valid;
    assign rx.code = st_ff.code;
endmodule

// ---- verification/tcd_top_asserts.sv ----
// Concurrent checks on the time-code block's ports
module tcd_top_asserts (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_link_run,
    input wire logic i_link_err_reset,
    input wire logic o_tx_tc_valid,
    input wire logic [7:0] o_tx_tc_code,
    input wire logic o_tick_out,
    input wire logic [5:0] o_time,
    input wire logic [1:0] o_ctrl_flags
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    sequence s_tick_once;
        o_tick_out ##1 !o_tick_out;
    endsequence
    sequence s_tx_once;
        o_tx_tc_valid ##1 !o_tx_tc_valid;
    endsequence
    property p_tick_pulse;
        o_tick_out |-> s_tick_once;
    endproperty
    a_tick_pulse: assert property (p_tick_pulse)
        else $error("tick out wider than one cycle");
    property p_tx_pulse;
        o_tx_tc_valid |-> s_tx_once;
    endproperty
    a_tx_pulse: assert property (p_tx_pulse)
        else $error("transmit request wider than one cycle");
    property p_tx_run;
        o_tx_tc_valid |-> $past(i_link_run);
    endproperty
    a_tx_run: assert property (p_tx_run)
        else $error("code sent while link not running");
    property p_tick_inc;
        o_tick_out |-> o_time == $past(o_time) + 6'h01;
    endproperty
    a_tick_inc: assert property (p_tick_inc)
        else $error("tick out without a plus one time step");
    property p_err_clear;
        i_link_err_reset |=> o_time == 6'h00 && o_ctrl_flags == 2'h0;
    endproperty
    a_err_clear: assert property (p_err_clear)
        else $error("link error reset left time or flags");
    property p_tick_no_err;
        o_tick_out |-> !$past(i_link_err_reset);
    endproperty
    a_tick_no_err: assert property (p_tick_no_err)
        else $error("tick out right after link error reset");
    property p_flags_hold;
        !o_tick_out && !$past(i_link_err_reset) |-> $stable(o_ctrl_flags);
    endproperty
    a_flags_hold: assert property (p_flags_hold)
        else $error("flags changed without a valid code");
    property p_tx_time;
        o_tx_tc_valid |-> o_tx_tc_code[5:0] == o_time;
    endproperty
    a_tx_time: assert property (p_tx_time)
        else $error("sent time differs from the counter");
endmodule

bind tcd_top tcd_top_asserts u_tcd_chk (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_link_run(i_link_run),
    .i_link_err_reset(i_link_err_reset), .o_tx_tc_valid(o_tx_tc_valid),
    .o_tx_tc_code(o_tx_tc_code), .o_tick_out(o_tick_out),
    .o_time(o_time), .o_ctrl_flags(o_ctrl_flags)
);

// ---- verification/tcd_link_peer.sv ----
// Far-end model presenting received time codes on the link clock
module tcd_link_peer (
    output logic o_link_clk,
    output logic o_stb,
    output logic [7:0] o_code
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_link_clk = 1'b0;
        o_stb = 1'b0;
        o_code = 8'h00;
    end
    // Clock runs only within a frame; offset keeps it out of phase
    task automatic send(input logic [7:0] c);
        #13;
        o_code = c;
        o_stb = 1'b1;
        #160;
        o_link_clk = 1'b1;
        #160;
        o_link_clk = 1'b0;
        // Released lines show the inverse, never the stale value
        o_stb = 1'b0;
        o_code = ~c;
    endtask
endmodule

// ---- verification/tb.sv ----
// Self-checking bench for the time-code distribution block
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic tick = 1'b0, run = 1'b0, err = 1'b0, busy = 1'b0, cend = 1'b0;
    logic [4:0] awa = 5'h00, ara = 5'h00;
    logic [31:0] wd = 32'h00000000;
    logic awr, wrdy, bv, arr, rv, txv, tick_out, irq, lclk, stb;
    logic [1:0] bresp, rresp, flags, r;
    logic [31:0] rdata, q;
    logic [5:0] tim;
    logic [7:0] tx_code, rxc, txc;
    logic got_tick, got_tx;
    int fails = 0;
    int checked = 0;
    initial begin
        forever #20 clk = ~clk;
    end
    tcd_top dut (
        .i_clk(clk), .i_rst_b(rst_b), .i_axi_awvalid(awv),
        .o_axi_awready(awr), .i_axi_awaddr(awa), .i_axi_wvalid(wv),
        .o_axi_wready(wrdy), .i_axi_wdata(wd), .i_axi_wstrb(4'hF),
        .o_axi_bvalid(bv), .i_axi_bready(bry), .o_axi_bresp(bresp),
        .i_axi_arvalid(arv), .o_axi_arready(arr), .i_axi_araddr(ara),
        .o_axi_rvalid(rv), .i_axi_rready(rry), .o_axi_rdata(rdata),
        .o_axi_rresp(rresp), .i_tick_in(tick), .i_link_run(run),
        .i_link_err_reset(err), .i_link_clk(lclk), .i_rx_tc_stb(stb),
        .i_rx_tc_code(rxc), .i_tx_busy(busy), .i_tx_char_end(cend),
        .o_tx_tc_valid(txv), .o_tx_tc_code(tx_code), .o_tick_out(tick_out),
        .o_time(tim), .o_ctrl_flags(flags), .o_irq(irq)
    );
    tcd_link_peer u_peer (.o_link_clk(lclk), .o_stb(stb), .o_code(rxc));
    task automatic close_out;
        $display("Counts: %0d checked, %0d failed", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Both channels offered together, each released when taken
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d);
        int n;
        logic ha, hw, ht, hb, done;
        @(posedge clk);
        if (w) begin
            awv <= 1'b1;
            wv <= 1'b1;
            awa <= a;
            wd <= d;
            bry <= 1'b1;
        end else begin
            arv <= 1'b1;
            ara <= a;
            rry <= 1'b1;
        end
        done = 1'b0;
        n = 0;
        while (!done && n < 60) begin
            @(negedge clk);
            ha = awv && awr;
            hw = wv && wrdy;
            ht = arv && arr;
            hb = (bv && bry) || (rv && rry);
            q = rdata;
            r = w ? bresp : rresp;
            @(posedge clk);
            if (ha) awv <= 1'b0;
            if (hw) wv <= 1'b0;
            if (ht) arv <= 1'b0;
            if (hb) begin
                bry <= 1'b0;
                rry <= 1'b0;
                done = 1'b1;
            end
            n++;
        end
        @(negedge clk);
        if (!done) begin
            fails++;
            $display("MISMATCH at %0t: bus timeout", $time);
            close_out;
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
        check(r, tcd_pkg::TCD_RESP_OKAY);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(r, tcd_pkg::TCD_RESP_OKAY);
        check(q, exp);
    endtask
    // Pulses are only observed here, never counted as time
    task automatic watch(input int n);
        got_tick = 1'b0;
        got_tx = 1'b0;
        repeat (n) begin
            @(negedge clk);
            if (tick_out === 1'b1) got_tick = 1'b1;
            if (txv === 1'b1) begin
                got_tx = 1'b1;
                txc = tx_code;
            end
        end
    endtask
    task automatic pulse_tick;
        @(posedge clk);
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
    endtask
    task automatic pulse_end;
        @(posedge clk);
        cend <= 1'b1;
        @(posedge clk);
        cend <= 1'b0;
    endtask
    task automatic rx_send(input logic [7:0] c);
        fork
            u_peer.send(c);
            watch(16);
        join
    endtask
    task automatic t_regs;
        rd(tcd_pkg::TCD_OFF_CTRL, 32'h00000000);
        bus(1'b0, 5'h1C, 32'h0);
        check(r, tcd_pkg::TCD_RESP_SLVERR);
        check(q, 32'h00000000);
        bus(1'b1, 5'h1C, 32'h000000FF);
        check(r, tcd_pkg::TCD_RESP_SLVERR);
        wr(tcd_pkg::TCD_OFF_CTRL, 32'h00000081);
        rd(tcd_pkg::TCD_OFF_CTRL, 32'h00000081);
        $display("register test done");
    endtask
    task automatic t_master;
        @(posedge clk);
        busy <= 1'b1;
        pulse_tick;
        watch(10);
        check(tim, 6'h01);
        check(got_tx, 1'b0);
        @(posedge clk);
        run <= 1'b1;
        watch(8);
        check(got_tx, 1'b0);
        fork
            pulse_end;
            watch(6);
        join
        check(got_tx, 1'b1);
        check(txc, 8'h81);
        check(irq, 1'b0);
        wr(tcd_pkg::TCD_OFF_IRQ_MASK, 32'h00000008);
        check(irq, 1'b1);
        rd(tcd_pkg::TCD_OFF_IRQ_STAT, 32'h00000018);
        check(irq, 1'b0);
        rd(tcd_pkg::TCD_OFF_STATUS, 32'h00000201);
        @(posedge clk);
        busy <= 1'b0;
        $display("master test done");
    endtask
    // Valid, equal, out of step, and valid across the wrap
    task automatic t_rx;
        logic [7:0] cs[4] = '{8'h42, 8'hC2, 8'h3F, 8'h80};
        logic [5:0] tt[4] = '{6'h02, 6'h02, 6'h3F, 6'h00};
        logic [1:0] fl[4] = '{2'h1, 2'h1, 2'h1, 2'h2};
        logic [3:0] et = 4'h9;
        wr(tcd_pkg::TCD_OFF_CTRL, 32'h00000000);
        for (int i = 0; i < 4; i++) begin
            rx_send(cs[i]);
            check(got_tick, et[i]);
            check(tim, tt[i]);
            check(flags, fl[i]);
        end
        $display("receive test done");
    endtask
    task automatic t_fwd;
        wr(tcd_pkg::TCD_OFF_CTRL, 32'h00000002);
        rx_send(8'h41);
        check(got_tick, 1'b1);
        check(got_tx, 1'b1);
        check(txc, 8'h41);
        rd(tcd_pkg::TCD_OFF_LAST, 32'h00004141);
        rd(tcd_pkg::TCD_OFF_COUNTS, 32'h00010103);
        wr(tcd_pkg::TCD_OFF_COUNTS, 32'h00000000);
        rd(tcd_pkg::TCD_OFF_COUNTS, 32'h00000000);
        $display("forward test done");
    endtask
    task automatic t_err;
        @(posedge clk);
        err <= 1'b1;
        @(posedge clk);
        err <= 1'b0;
        @(negedge clk);
        check(tim, 6'h00);
        check(flags, 2'h0);
        // Software tick ignored until master is set
        wr(tcd_pkg::TCD_OFF_SWTICK, 32'h00000001);
        check(tim, 6'h00);
        wr(tcd_pkg::TCD_OFF_CTRL, 32'h00000001);
        wr(tcd_pkg::TCD_OFF_SWTICK, 32'h00000001);
        check(tim, 6'h01);
        $display("error reset test done");
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        check(tim, 6'h00);
        t_regs;
        t_master;
        t_rx;
        t_fwd;
        t_err;
        close_out;
    end
endmodule
